/* flash_dev_model.sv */
// Purpose: behavioural flash device facing flash_host
// Assumes: pins sampled on aclk; sector is addr[17:12]
// Notes:   16-word array, one protected sector; overrun stalls work
`timescale 1ns/100ps
module flash_dev_model #(
   parameter int          BUSY = 200,
   parameter int          WIN  = 1500,
   parameter logic [17:0] UA1  = 18'h00555,
   parameter logic [17:0] UA2  = 18'h002aa,
   parameter logic [7:0]  UD1  = 8'haa,
   parameter logic [7:0]  UD2  = 8'h55,
   parameter logic [5:0]  PSEC = 6'h3f, // protected sector
   parameter int          PCYC = 100    // protected toggle span, 2 us
) (
   input  wire logic        aclk,
   input  wire logic [17:0] addr,
   input  wire logic [15:0] dq_in,
   output logic [15:0]      dq,
   input  wire logic        ce_n,
   input  wire logic        oe_n,
   input  wire logic        we_n,
   input  wire logic        overrun,
   output logic             ready_busy_n
);
   // -----------------------------------
   // command state
   // -----------------------------------
   logic [15:0] mem [16];
   logic [63:0] sel = '0;
   logic [17:0] la = '0, pa = '0;
   logic [15:0] pd = '0, lst = '0, rv;
   logic [7:0]  d;
   logic        wq = 1'h0, rq = 1'h0, tog = 1'h0, stog = 1'h0, susp = 1'h0;
   int          mode = 0, seq = 0, cnt = 0, wcnt = 0, nwr = 0, nsec = 0;
   wire         wr  = !ce_n && !we_n;
   wire         rd  = !ce_n && !oe_n;
   wire         hit = sel[addr[17:12]];
   wire         run = mode == 1 || mode == 3;
   initial foreach (mem[i]) mem[i] = 16'h0000;
   // unlock chain; erase setup refused while suspended
   function automatic int nxt(int s, logic [17:0] a, logic [7:0] v);
      if ((s == 0 || s == 3) && a == UA1 && v == UD1) return s + 1;
      if ((s == 1 || s == 4) && a == UA2 && v == UD2) return s + 1;
      if (s == 2 && v == 8'h80 && mode == 0) return 3;
      if (s == 2 && v == 8'ha0) return 6;
      return 0;
   endfunction
   // mode 0 read, 1 program, 2 load window, 3 erase, 4 suspended
   always_comb begin
      rv = mem[addr[3:0]];
      if (mode == 1) rv = {8'h00, ~pd[7], tog, overrun, 5'h00};
      else if (mode == 2 || mode == 3) rv = {9'h000, tog, overrun, 1'h0, mode == 3, hit & stog, 2'h0};
      else if (mode == 4 && hit) rv = {8'h00, 1'h1, tog, 3'h0, stog, 2'h0};
   end
   // released bus shows the inverse of its last value, never a stale copy
   assign dq = rd ? rv : ~lst;
   assign ready_busy_n = !(run || mode == 2);
   // address taken on strobe fall, command on strobe rise
   always @(posedge aclk) begin
      wq <= wr;
      rq <= rd;
      if (rd) lst <= rv;
      if (wr && !wq) la <= addr;
      if (rq && !rd && (run || mode == 2)) tog <= ~tog;
      if (rq && !rd && hit) stog <= ~stog;
      if (run && !overrun && cnt > 0) cnt <= cnt - 1;
      if (run && !overrun && cnt == 1) begin
         mode <= susp ? 4 : 0;
         if (mode == 1) mem[pa[3:0]] <= pd;
      end
      if (mode == 2) wcnt <= wcnt - 1;
      if (mode == 2 && wcnt == 1) begin
         mode <= 3;
         cnt  <= (sel & ~(64'h1 << PSEC)) == 64'h0 ? PCYC : BUSY;
      end
      if (wq && !wr) begin
         d = dq_in[7:0];
         nwr <= nwr + 1;
         if (d == 8'hf0) begin
            seq  <= 0;
            mode <= susp ? 4 : 0;
         end else if (mode == 1) begin
         end else if (seq == 6) begin
            seq  <= 0;
            pa   <= la;
            pd   <= la[17:12] == PSEC ? mem[la[3:0]] : dq_in;
            mode <= 1;
            cnt  <= la[17:12] == PSEC ? PCYC : BUSY;
         end else if (mode >= 2 && mode <= 3 && d == 8'hb0) begin
            mode <= 4;
            susp <= 1'h1;
            cnt  <= mode == 2 ? BUSY : cnt;
         end else if (mode == 3) begin
         end else if (mode == 2 && d == 8'h30) begin
            sel[la[17:12]] <= 1'h1;
            nsec <= nsec + 1;
            wcnt <= WIN;
         end else if (mode == 2) mode <= 0;
         else if (mode == 4 && seq == 0 && d == 8'h30) begin
            mode <= 3;
            susp <= 1'h0;
         end else if (seq == 5 && d == 8'h30) begin
            sel  <= 64'h1 << la[17:12];
            nsec <= 1;
            mode <= 2;
            wcnt <= WIN;
            seq  <= 0;
         end else seq <= nxt(seq, la, d);
      end
   end
endmodule // flash_dev_model

/* flash_host.sv */
// Purpose: AXI4-Lite controlled host that issues flash command sequences
//          and polls status until a program or resume completes
// Assumes: flash pins synchronous to aclk; one operation at a time
// Notes:   completion judged by two consecutive equal toggle reads
//
// Added by the designer: the placing of the registers and the AXI4-Lite interface to the registers.
`timescale 1ns/100ps
module flash_host #(
   parameter logic [17:0] UNLOCK_ADDR1 = 18'h00555,
   parameter logic [17:0] UNLOCK_ADDR2 = 18'h002aa,
   parameter logic [7:0]  UNLOCK_DATA1 = 8'haa,
   parameter logic [7:0]  UNLOCK_DATA2 = 8'h55
) (
   input  wire  logic        aclk,
   input  wire  logic        aresetn,
   input  wire  logic [7:0]  s_axi_awaddr,
   input  wire  logic        s_axi_awvalid,
   output logic              s_axi_awready,
   input  wire  logic [31:0] s_axi_wdata,
   input  wire  logic [3:0]  s_axi_wstrb,
   input  wire  logic        s_axi_wvalid,
   output logic              s_axi_wready,
   output logic [1:0]        s_axi_bresp,
   output logic              s_axi_bvalid,
   input  wire  logic        s_axi_bready,
   input  wire  logic [7:0]  s_axi_araddr,
   input  wire  logic        s_axi_arvalid,
   output logic              s_axi_arready,
   output logic [31:0]       s_axi_rdata,
   output logic [1:0]        s_axi_rresp,
   output logic              s_axi_rvalid,
   input  wire  logic        s_axi_rready,
   output logic [17:0]       flash_addr,
   output logic [15:0]       flash_dq_o,
   output logic              flash_dq_oe,
   input  wire  logic [15:0] flash_dq_i,
   output logic              flash_ce_n,
   output logic              flash_oe_n,
   output logic              flash_we_n,
   input  wire  logic        ready_busy_n
);

   // ---------------------------------------------------------------------
   // sequencer states
   // ---------------------------------------------------------------------
   typedef enum logic [2:0] {ST_IDLE, ST_WSETUP, ST_WSTROBE, ST_WHOLD, ST_RSTROBE, ST_DECIDE} state_t;

   state_t      state_ff, nxt_state;
   logic [2:0]  step_ff, nxt_step;
   logic [2:0]  nsteps_ff, nxt_nsteps;
   logic [2:0]  cnt_ff, nxt_cnt;
   logic [17:0] addr_ff, nxt_addr;
   logic [15:0] data_ff, nxt_data;
   logic [15:0] rd_ff, nxt_rd;
   logic        prev_tog_ff, nxt_prev_tog, have_prev_ff, nxt_have_prev, poll_ff, nxt_poll;
   logic        busy_ff, nxt_busy, done_ff, nxt_done, fail_ff, nxt_fail;
   logic        limit_seen_ff, nxt_limit_seen, window_ff, nxt_window;
   logic [10:0] win_cnt_ff, nxt_win_cnt;
   flash_host_pkg::op_t        op_ff, nxt_op;
   logic                       go;
   flash_host_pkg::op_t        go_op;
   flash_host_pkg::bus_cycle_t cyc;
   logic        tog_now, equal_tog;

   // ---------------------------------------------------------------------
   // axi slave: single-cycle accept, answer next cycle
   // ---------------------------------------------------------------------
   logic        bvalid_ff, nxt_bvalid, rvalid_ff, nxt_rvalid;
   logic [31:0] rdata_ff, nxt_rdata;
   logic        wr_take, rd_take;

   assign s_axi_awready = s_axi_awvalid & s_axi_wvalid & ~bvalid_ff;
   assign s_axi_wready  = s_axi_awready;
   assign s_axi_arready = s_axi_arvalid & ~rvalid_ff;
   assign wr_take       = s_axi_awready;
   assign rd_take       = s_axi_arready;
   assign s_axi_bvalid  = bvalid_ff;
   assign s_axi_bresp   = 2'h0;
   assign s_axi_rvalid  = rvalid_ff;
   assign s_axi_rdata   = rdata_ff;
   assign s_axi_rresp   = 2'h0;
   // go is ignored while a sequence runs
   assign go    = wr_take & (s_axi_awaddr == flash_host_pkg::ADDR_CTRL) & s_axi_wstrb[0]
                  & s_axi_wdata[flash_host_pkg::CTRL_GO_BIT] & ~busy_ff;
   assign go_op = flash_host_pkg::op_t'(s_axi_wdata[flash_host_pkg::CTRL_OP_LSB +: 3]);

   // bus answer and read mux
   always_comb begin
      nxt_bvalid = bvalid_ff;
      nxt_rvalid = rvalid_ff;
      nxt_rdata  = rdata_ff;
      if (wr_take) begin
         nxt_bvalid = 1'b1;
      end else if (s_axi_bready) begin
         nxt_bvalid = 1'b0;
      end
      if (rd_take) begin
         nxt_rvalid = 1'b1;
         unique case (s_axi_araddr)
            flash_host_pkg::ADDR_CTRL:   nxt_rdata = {25'h0, 3'(op_ff), 4'h0};
            flash_host_pkg::ADDR_ADDR:   nxt_rdata = {14'h0, addr_ff};
            flash_host_pkg::ADDR_DATA:   nxt_rdata = {16'h0, data_ff};
            flash_host_pkg::ADDR_STATUS: nxt_rdata = {18'h0, window_ff, ready_busy_n, limit_seen_ff,
                                                      fail_ff, done_ff, busy_ff, rd_ff[7:0]};
            flash_host_pkg::ADDR_RDATA:  nxt_rdata = {16'h0, rd_ff};
            default:                     nxt_rdata = 32'h0;
         endcase
      end else if (s_axi_rready) begin
         nxt_rvalid = 1'b0;
      end
   end

   // ---------------------------------------------------------------------
   // command table: one bus cycle per step
   // ---------------------------------------------------------------------
   always_comb begin
      cyc.wr   = 1'b1;
      cyc.addr = UNLOCK_ADDR1;
      cyc.data = {8'h0, UNLOCK_DATA1};
      unique case (op_ff)
         flash_host_pkg::OP_PROGRAM: begin
            unique case (step_ff)
               3'd1: begin cyc.addr = UNLOCK_ADDR2; cyc.data = {8'h0, UNLOCK_DATA2}; end
               3'd2: cyc.data = {8'h0, flash_host_pkg::CMD_PROGRAM};
               3'd3: begin cyc.addr = addr_ff; cyc.data = data_ff; end
               default: ;
            endcase
         end
         flash_host_pkg::OP_ERASE_FIRST: begin
            unique case (step_ff)
               3'd1: begin cyc.addr = UNLOCK_ADDR2; cyc.data = {8'h0, UNLOCK_DATA2}; end
               3'd2: cyc.data = {8'h0, flash_host_pkg::CMD_ERASE_SETUP};
               3'd4: begin cyc.addr = UNLOCK_ADDR2; cyc.data = {8'h0, UNLOCK_DATA2}; end
               3'd5: begin cyc.addr = addr_ff; cyc.data = {8'h0, flash_host_pkg::CMD_SECTOR_ERASE}; end
               default: ;
            endcase
         end
         flash_host_pkg::OP_ERASE_MORE: begin
            cyc.addr = addr_ff;
            cyc.data = {8'h0, flash_host_pkg::CMD_SECTOR_ERASE};
         end
         flash_host_pkg::OP_SUSPEND: cyc.data = {8'h0, flash_host_pkg::CMD_SUSPEND};
         flash_host_pkg::OP_RESUME:  cyc.data = {8'h0, flash_host_pkg::CMD_RESUME};
         flash_host_pkg::OP_RESET:   cyc.data = {8'h0, flash_host_pkg::CMD_READ_RESET};
         flash_host_pkg::OP_READ: begin
            cyc.wr   = 1'b0;
            cyc.addr = addr_ff;
         end
         default: ;
      endcase
   end

   // status interpretation of the last read
   assign tog_now   = rd_ff[flash_host_pkg::BIT_TOGGLE];
   assign equal_tog = have_prev_ff & (tog_now == prev_tog_ff);

   // ---------------------------------------------------------------------
   // sequencer
   // ---------------------------------------------------------------------
   always_comb begin
      nxt_state      = state_ff;
      nxt_step       = step_ff;
      nxt_nsteps     = nsteps_ff;
      nxt_cnt        = cnt_ff;
      nxt_addr       = addr_ff;
      nxt_data       = data_ff;
      nxt_rd         = rd_ff;
      nxt_prev_tog   = prev_tog_ff;
      nxt_have_prev  = have_prev_ff;
      nxt_poll       = poll_ff;
      nxt_busy       = busy_ff;
      nxt_done       = done_ff;
      nxt_fail       = fail_ff;
      nxt_limit_seen = limit_seen_ff;
      nxt_op         = op_ff;
      nxt_window     = window_ff;
      nxt_win_cnt    = win_cnt_ff;
      // load window closes 30 us after the last sector write
      if (window_ff) begin
         if (win_cnt_ff == 11'(flash_host_pkg::LOAD_WINDOW_CYC - 1)) begin
            nxt_window = 1'b0;
         end else begin
            nxt_win_cnt = win_cnt_ff + 11'd1;
         end
      end
      // register writes while idle
      if (wr_take && !busy_ff) begin
         if (s_axi_awaddr == flash_host_pkg::ADDR_ADDR) nxt_addr = s_axi_wdata[17:0];
         if (s_axi_awaddr == flash_host_pkg::ADDR_DATA) nxt_data = s_axi_wdata[15:0];
      end
      unique case (state_ff)
         ST_IDLE: begin
            if (go) begin
               nxt_op        = go_op;
               nxt_busy      = 1'b1;
               nxt_done      = 1'b0;
               nxt_fail      = 1'b0;
               nxt_limit_seen = 1'b0;
               nxt_have_prev = 1'b0;
               nxt_step      = 3'd0;
               nxt_state     = ST_WSETUP;
               unique case (go_op)
                  flash_host_pkg::OP_PROGRAM:     nxt_nsteps = 3'd4;
                  flash_host_pkg::OP_ERASE_FIRST: nxt_nsteps = 3'd6;
                  default:                        nxt_nsteps = 3'd1;
               endcase
               // a further sector only inside the open window
               if (go_op == flash_host_pkg::OP_ERASE_MORE && !window_ff) begin
                  nxt_busy  = 1'b0;
                  nxt_fail  = 1'b1;
                  nxt_done  = 1'b1;
                  nxt_state = ST_IDLE;
               end
            end
         end
         ST_WSETUP: begin
            nxt_cnt   = 3'd0;
            nxt_state = cyc.wr ? ST_WSTROBE : ST_RSTROBE;
         end
         ST_WSTROBE: begin
            nxt_cnt = cnt_ff + 3'd1;
            if (cnt_ff == 3'(flash_host_pkg::STROBE_CYC - 1)) nxt_state = ST_WHOLD;
         end
         ST_WHOLD: begin
            nxt_step = step_ff + 3'd1;
            if (step_ff + 3'd1 == nsteps_ff) begin
               unique case (op_ff)
                  flash_host_pkg::OP_PROGRAM, flash_host_pkg::OP_RESUME: begin
                     nxt_poll  = 1'b1;
                     nxt_state = ST_WSETUP;
                     nxt_op    = flash_host_pkg::OP_READ;
                  end
                  flash_host_pkg::OP_ERASE_FIRST, flash_host_pkg::OP_ERASE_MORE: begin
                     nxt_window  = 1'b1;
                     nxt_win_cnt = 11'd0;
                     nxt_busy    = 1'b0;
                     nxt_done    = 1'b1;
                     nxt_state   = ST_IDLE;
                  end
                  default: begin
                     nxt_window = 1'b0;
                     nxt_busy   = 1'b0;
                     nxt_done   = 1'b1;
                     nxt_state  = ST_IDLE;
                  end
               endcase
            end else begin
               nxt_state = ST_WSETUP;
            end
         end
         ST_RSTROBE: begin
            nxt_cnt = cnt_ff + 3'd1;
            if (cnt_ff == 3'(flash_host_pkg::STROBE_CYC - 1)) begin
               nxt_rd    = flash_dq_i;
               nxt_state = ST_DECIDE;
            end
         end
         ST_DECIDE: begin
            nxt_prev_tog  = tog_now;
            nxt_have_prev = 1'b1;
            if (rd_ff[flash_host_pkg::BIT_LIMIT]) nxt_limit_seen = 1'b1;
            if (!poll_ff || equal_tog || (limit_seen_ff && have_prev_ff)) begin
               nxt_busy  = 1'b0;
               nxt_done  = 1'b1;
               nxt_fail  = poll_ff & limit_seen_ff;
               nxt_poll  = 1'b0;
               nxt_state = ST_IDLE;
            end else begin
               nxt_state = ST_WSETUP;
            end
         end
         default: nxt_state = ST_IDLE;
      endcase
   end

   // registers
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         state_ff <= ST_IDLE;
         step_ff <= 3'd0;
         nsteps_ff <= 3'd0;
         cnt_ff <= 3'd0;
         addr_ff <= 18'h0;
         data_ff <= 16'h0;
         rd_ff <= 16'h0;
         {prev_tog_ff, have_prev_ff, poll_ff, busy_ff} <= 4'h0;
         {done_ff, fail_ff, limit_seen_ff, window_ff} <= 4'h0;
         win_cnt_ff <= 11'h0;
         op_ff <= flash_host_pkg::OP_READ;
         {bvalid_ff, rvalid_ff} <= 2'h0;
         rdata_ff <= 32'h0;
      end else begin
         state_ff <= nxt_state;
         step_ff <= nxt_step;
         nsteps_ff <= nxt_nsteps;
         cnt_ff <= nxt_cnt;
         addr_ff <= nxt_addr;
         data_ff <= nxt_data;
         rd_ff <= nxt_rd;
         {prev_tog_ff, have_prev_ff, poll_ff, busy_ff} <= {nxt_prev_tog, nxt_have_prev, nxt_poll, nxt_busy};
         {done_ff, fail_ff, limit_seen_ff, window_ff} <= {nxt_done, nxt_fail, nxt_limit_seen, nxt_window};
         win_cnt_ff <= nxt_win_cnt;
         op_ff <= nxt_op;
         {bvalid_ff, rvalid_ff} <= {nxt_bvalid, nxt_rvalid};
         rdata_ff <= nxt_rdata;
      end
   end

   // ---------------------------------------------------------------------
   // pin drive: address/data held through setup, strobe, hold
   // ---------------------------------------------------------------------
   assign flash_addr  = cyc.addr;
   assign flash_dq_o  = cyc.data;
   assign flash_dq_oe = cyc.wr & (state_ff != ST_IDLE) & (state_ff != ST_DECIDE);
   assign flash_ce_n  = ~((state_ff == ST_WSTROBE) | (state_ff == ST_RSTROBE) | (state_ff == ST_WSETUP));
   assign flash_we_n  = ~(state_ff == ST_WSTROBE);
   assign flash_oe_n  = ~(state_ff == ST_RSTROBE);

   // ---------------------------------------------------------------------
   // checks
   // ---------------------------------------------------------------------
   AST_WE_OE_EXCL: assert property (@(posedge aclk) disable iff (!aresetn)
      !(!flash_we_n && !flash_oe_n)) else $error("we and oe low together");
   AST_WE_WIDTH: assert property (@(posedge aclk) disable iff (!aresetn)
      $fell(flash_we_n) |-> !flash_we_n [*4] ##1 flash_we_n) else $error("write strobe width");
   AST_ERASE_SEQ: assert property (@(posedge aclk) disable iff (!aresetn)
      (state_ff == ST_WSTROBE && op_ff == flash_host_pkg::OP_ERASE_FIRST && step_ff == 3'd2)
      |-> flash_dq_o[7:0] == flash_host_pkg::CMD_ERASE_SETUP) else $error("erase setup byte");
   AST_PROG_SEQ: assert property (@(posedge aclk) disable iff (!aresetn)
      (state_ff == ST_WSTROBE && op_ff == flash_host_pkg::OP_PROGRAM && step_ff == 3'd2)
      |-> flash_dq_o[7:0] == flash_host_pkg::CMD_PROGRAM) else $error("program byte");
   AST_WINDOW: assert property (@(posedge aclk) disable iff (!aresetn)
      $rose(window_ff) |-> window_ff [*8]) else $error("load window closed early");
   AST_POLL_DONE: assert property (@(posedge aclk) disable iff (!aresetn)
      (state_ff == ST_DECIDE && poll_ff && equal_tog) |=> done_ff && !busy_ff) else $error("not done");
   AST_LIMIT: assert property (@(posedge aclk) disable iff (!aresetn)
      (state_ff == ST_DECIDE && rd_ff[flash_host_pkg::BIT_LIMIT]) |=> limit_seen_ff) else $error("limit lost");
   AST_MORE_REFUSE: assert property (@(posedge aclk) disable iff (!aresetn)
      (go && go_op == flash_host_pkg::OP_ERASE_MORE && !window_ff) |=> fail_ff && !busy_ff)
      else $error("sector outside window taken");

endmodule // flash_host

/* flash_host_pkg.sv */
// Purpose: constants and carriers for the flash command/status host controller
// Assumes: 50 MHz aclk, device pins sampled synchronously
// Notes:   unlock addresses/data are parameters with plain defaults
package flash_host_pkg;

   // ---------------------------------------------------------------------
   // axi register map of the controller
   // ---------------------------------------------------------------------
   localparam logic [7:0] ADDR_CTRL   = 8'h00; // go, opcode
   localparam logic [7:0] ADDR_ADDR   = 8'h04; // target word address
   localparam logic [7:0] ADDR_DATA   = 8'h08; // program data
   localparam logic [7:0] ADDR_STATUS = 8'h0c; // busy, done, fail, last status
   localparam logic [7:0] ADDR_RDATA  = 8'h10; // last read word

   localparam int CTRL_GO_BIT = 0;
   localparam int CTRL_OP_LSB = 4;

   // ---------------------------------------------------------------------
   // command bytes and status bit positions
   // ---------------------------------------------------------------------
   localparam logic [7:0] CMD_ERASE_SETUP = 8'h80;
   localparam logic [7:0] CMD_SECTOR_ERASE = 8'h30;
   localparam logic [7:0] CMD_SUSPEND     = 8'hb0;
   localparam logic [7:0] CMD_RESUME      = 8'h30;
   localparam logic [7:0] CMD_PROGRAM     = 8'ha0;
   localparam logic [7:0] CMD_READ_RESET  = 8'hf0;

   localparam int BIT_POLL   = 7;
   localparam int BIT_TOGGLE = 6;
   localparam int BIT_LIMIT  = 5;
   localparam int BIT_TIMER  = 3;
   localparam int BIT_STOG   = 2;

   // ---------------------------------------------------------------------
   // timing
   // ---------------------------------------------------------------------
   localparam int CLK_MHZ         = 50;
   localparam int LOAD_WINDOW_US  = 30;
   localparam int LOAD_WINDOW_CYC = LOAD_WINDOW_US * CLK_MHZ; // longest: round down
   localparam int STROBE_CYC      = 4; // strobe low width, 80 ns
   localparam int RESET_VAL_ZERO  = 0;

   // operations software may request
   typedef enum logic [2:0] {
      OP_READ, OP_PROGRAM, OP_ERASE_FIRST, OP_ERASE_MORE, OP_SUSPEND, OP_RESUME, OP_RESET
   } op_t;

   // one bus cycle toward the flash
   typedef struct packed {
      logic        wr;
      logic [17:0] addr;
      logic [15:0] data;
   } bus_cycle_t;

endpackage

/* test_flash_host.sv */
// Purpose: self-checking bench for flash_host with a flash model
// Assumes: 50 MHz aclk, reset low for 6 cycles
// Notes:   read answers checked by a monitor against queued notes
`timescale 1ns/100ps
module test_flash_host;
   // -----------------------------------
   // signals and instances
   // -----------------------------------
   localparam logic [7:0] ST = flash_host_pkg::ADDR_STATUS;
   localparam logic [7:0] RW = flash_host_pkg::ADDR_RDATA;
   localparam logic [7:0] DW = flash_host_pkg::ADDR_DATA;
   logic        aclk = 1'h0, aresetn = 1'h0, ovr = 1'h0;
   logic [7:0]  awaddr = 8'h00, araddr = 8'h00;
   logic [31:0] wdata = 32'h0, last = 32'h0, rdata;
   logic        awvalid = 1'h0, wvalid = 1'h0, bready = 1'h0, arvalid = 1'h0, rready = 1'h0;
   logic        awready, wready, bvalid, arready, rvalid, dqoe, ce_n, oe_n, we_n, rbn;
   logic [1:0]  bresp, rresp;
   logic [17:0] faddr, a;
   logic [15:0] dqo, mdq, d;
   wire  [15:0] bus = dqoe ? dqo : mdq;
   logic [31:0] qe[$], qm[$];
   int          mismatches = 0, n_checks = 0, n;
   flash_host u_flash_host (
      .aclk(aclk), .aresetn(aresetn),
      .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
      .s_axi_wdata(wdata), .s_axi_wstrb(4'hf), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
      .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
      .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
      .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
      .flash_addr(faddr), .flash_dq_o(dqo), .flash_dq_oe(dqoe), .flash_dq_i(bus),
      .flash_ce_n(ce_n), .flash_oe_n(oe_n), .flash_we_n(we_n), .ready_busy_n(rbn));
   flash_dev_model u_flash_dev_model (.aclk(aclk), .addr(faddr), .dq_in(bus), .dq(mdq), .ce_n(ce_n),
      .oe_n(oe_n), .we_n(we_n), .overrun(ovr), .ready_busy_n(rbn));
   always #10 aclk = ~aclk;
   // -----------------------------------
   // tasks
   // -----------------------------------
   task automatic chk(input logic [31:0] s, input logic [31:0] e);
      n_checks++;
      if (s !== e) begin
         mismatches++;
         $display("FAIL t=%0t seen=%h exp=%h", $time, s, e);
      end
   endtask
   task automatic end_sim;
      if (mismatches == 0 && n_checks > 0) $display("NO MISMATCHES");
      else $display("MISMATCHES SEEN");
      $finish;
   endtask
   // payload held until its own ready edge
   task automatic wr(input logic [7:0] ad, input logic [31:0] v);
      @(posedge aclk);
      awaddr  <= ad;
      wdata   <= v;
      awvalid <= 1'h1;
      wvalid  <= 1'h1;
      bready  <= 1'h1;
      do @(posedge aclk); while (awready !== 1'h1);
      awvalid <= 1'h0;
      wvalid  <= 1'h0;
      do @(posedge aclk); while (bvalid !== 1'h1);
      bready  <= 1'h0;
   endtask
   // mask of zero: a poll whose answer is not judged
   task automatic rd(input logic [7:0] ad, input logic [31:0] m, input logic [31:0] e);
      qm.push_back(m);
      qe.push_back(e);
      @(posedge aclk);
      araddr  <= ad;
      arvalid <= 1'h1;
      rready  <= 1'h1;
      do @(posedge aclk); while (arready !== 1'h1);
      arvalid <= 1'h0;
      do @(posedge aclk); while (rvalid !== 1'h1);
      last = rdata;
      rready  <= 1'h0;
   endtask
   // address, go, then poll done with a bounded count
   task automatic op(input int o, input logic [17:0] ad);
      int i = 0;
      wr(flash_host_pkg::ADDR_ADDR, 32'(ad));
      wr(flash_host_pkg::ADDR_CTRL, (32'(o) << flash_host_pkg::CTRL_OP_LSB) | 32'h1);
      do begin
         rd(ST, 32'h0, 32'h0);
         i++;
      end while (last[9] !== 1'h1 && i < 500);
      if (last[9] !== 1'h1) mismatches++;
   endtask
   // monitor: each read answer against the oldest note
   always @(posedge aclk) begin
      if (rvalid === 1'h1 && rready === 1'h1 && qm.size() > 0) begin
         if (qm[0] != 0) chk(rdata & qm[0], qe[0]);
         void'(qm.pop_front());
         void'(qe.pop_front());
      end
   end
   // -----------------------------------
   // scenarios
   // -----------------------------------
   initial begin
      void'($urandom(32'h5b09f9d4));
      a = {6'h03, 8'h00, 4'($urandom)};
      d = 16'($urandom);
      repeat (6) @(posedge aclk);
      aresetn <= 1'h1;
      n = u_flash_dev_model.nwr;
      wr(DW, 32'(d));
      op(1, a);
      rd(ST, 32'h0600, 32'h0200);
      chk(u_flash_dev_model.nwr - n, 4);
      op(0, a);
      rd(RW, 32'hffff, 32'(d));
      rd(8'h20, 32'hffffffff, 32'h0);
      n = u_flash_dev_model.nwr;
      op(2, 18'h05000);
      chk(u_flash_dev_model.nwr - n, 6);
      op(0, 18'h05000);
      rd(ST, 32'h0088, 32'h0000);
      op(3, 18'h06000);
      chk(u_flash_dev_model.nsec, 2);
      op(4, 18'h06000);
      chk(u_flash_dev_model.mode, 4);
      chk(32'(rbn), 1);
      op(0, a);
      rd(RW, 32'hffff, 32'(d));
      op(0, 18'h05000);
      rd(ST, 32'h0080, 32'h0080);
      op(5, 18'h05000);
      rd(ST, 32'h0600, 32'h0200);
      chk(u_flash_dev_model.mode, 0);
      op(2, 18'h07000);
      repeat (1800) @(posedge aclk);
      chk(u_flash_dev_model.mode, 0);
      op(3, 18'h07000);
      rd(ST, 32'h0400, 32'h0400);
      chk(u_flash_dev_model.nsec, 1);
      ovr <= 1'h1;
      wr(DW, 32'(~d));
      op(1, a);
      rd(ST, 32'h0c00, 32'h0c00);
      chk(32'(rbn), 0);
      ovr <= 1'h0;
      op(6, a);
      chk(u_flash_dev_model.mode, 0);
      wr(DW, 32'(~d));
      op(1, {6'h3f, a[11:0]});
      op(0, a);
      rd(RW, 32'hffff, 32'(d));
      op(2, 18'h3f000);
      repeat (1650) @(posedge aclk);
      chk(u_flash_dev_model.mode, 0);
      end_sim;
   end
   // watchdog: the run needs a few thousand cycles
   initial begin
      #600000;
      mismatches++;
      end_sim;
   end
endmodule // test_flash_host
